//--- core/dppmr_pkg.sv
// Constants and carrier types for the dual-port transceiver register bank.
// Assumes a 16-bit register port with byte offsets and bank selection at 0xE.
package dppmr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          DPPMR_AW          = 4;
  localparam int          DPPMR_DW          = 16;
  localparam int          DPPMR_BW          = 8;
  localparam logic [7:0]  DPPMR_BANK_PORT1  = 8'h2D;
  localparam logic [7:0]  DPPMR_BANK_PORT2  = 8'h2E;
  localparam logic [7:0]  DPPMR_BANK_RST    = 8'h00;
  localparam logic [3:0]  DPPMR_OFS_CTL     = 4'h0;
  localparam logic [3:0]  DPPMR_OFS_STS     = 4'h2;
  localparam logic [3:0]  DPPMR_OFS_IDL     = 4'h4;
  localparam logic [3:0]  DPPMR_OFS_IDH     = 4'h6;
  localparam logic [3:0]  DPPMR_OFS_ADV     = 4'h8;
  localparam logic [3:0]  DPPMR_OFS_LPA     = 4'hA;
  localparam logic [3:0]  DPPMR_OFS_BANK    = 4'hE;

  // ************************************************************
  // Basic control fields
  // ************************************************************
  localparam int          CTL_FAR_LB        = 14;
  localparam int          CTL_SPEED_100     = 13;
  localparam int          CTL_AN_EN         = 12;
  localparam int          CTL_PWR_DOWN      = 11;
  localparam int          CTL_AN_RESTART    = 9;
  localparam int          CTL_FULL_DUPLEX   = 8;
  localparam int          CTL_XOVER_ALG     = 5;
  localparam int          CTL_FORCE_MDIX    = 4;
  localparam int          CTL_MDIX_OFF      = 3;
  localparam int          CTL_FEF_OFF       = 2;
  localparam int          CTL_TX_OFF        = 1;
  localparam int          CTL_LED_OFF       = 0;
  localparam logic [15:0] CTL_WR_MASK       = 16'h793F;
  localparam logic [15:0] CTL_RST           = 16'h1020;

  // ************************************************************
  // Status, advertisement and partner fields
  // ************************************************************
  localparam logic [15:0] STS_FIXED         = 16'h7808;
  localparam int          STS_FEF           = 4;
  localparam int          STS_LINK          = 2;
  localparam logic [15:0] ADV_WR_MASK       = 16'h07E0;
  localparam logic [15:0] ADV_RST           = 16'h05E0;
  localparam logic [15:0] ADV_SELECTOR      = 16'h0001;
  localparam logic [15:0] LPA_LOW_FIXED     = 16'h0001;
  localparam int          ABL_PAUSE         = 10;
  localparam int          ABL_LOW           = 5;
  localparam logic [15:0] ZERO16            = 16'h0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } dppmr_sym_t;

  typedef struct packed {
    logic       link_up;
    logic       far_fault;
    logic       an_fail;
    logic       an_res_100;
    logic       an_res_full;
    logic       mdix_auto;
    logic [4:0] partner;    // pause, 100F, 100H, 10F, 10H
  } dppmr_phy_sts_t;

  typedef struct packed {
    logic       an_en;
    logic       an_restart;
    logic       speed_100;
    logic       full_duplex;
    logic       power_down;
    logic       xover_alg;
    logic       auto_mdix_en;
    logic       mdix_sel;
    logic       fef_det_en;
    logic       tx_off;
    logic       led_on;
    logic [4:0] advertise;
  } dppmr_phy_ctl_t;

endpackage

//--- core/dppmr_regs.sv
// Per-port basic control/status register bank for two embedded transceivers,
// with the far-end loopback symbol paths. Assumes a synchronous host register
// port and transceiver status inputs synchronous to sys_clk.
`timescale 1ns/1ps

// Behaviour
// - Port1 loop bit loops port2 rx to tx
// - Port2 loop bit loops port1 rx to tx
// - Bit 13 forces speed when negotiation off
// - Bit 8 forces duplex when off or failed
// - Bit 12 enables negotiation, resets to one
// - Port 1 never negotiates
// - Writing one to bit 9 restarts negotiation
// - Bit 11 powers the transceiver down
// - Bit 5 selects crossover algorithm, resets set
// - Bit 4 forces crossed pair assignment
// - Bit 3 disables automatic crossover
// - Port1 bit 2 disables far-end fault
// - Bit 1 stops cable transmission
// - Bit 0 turns the LED off
// - Unsupported control and advert bits read zero
// - Capability bits 14-11 one, bit 15 zero
// - Port1 status bit 4 shows far-end fault
// - Status bit 2 shows link state
// - Advert bits writable, selector reads 0x01
// - Partner ability read-only, clears at reset
// - Two fixed identifier registers per port
module dppmr_regs
  import dppmr_pkg::*;
#(
  parameter logic [15:0] ID_LOW  = 16'h5A5A,  // Arbitrary value
  parameter logic [15:0] ID_HIGH = 16'hA5A5   // Arbitrary value
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [DPPMR_AW-1:0]   reg_addr,
  input  wire logic [DPPMR_DW-1:0]   reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DPPMR_DW-1:0]   reg_rdata,
  input  wire dppmr_phy_sts_t [1:0]  phy_sts,
  output dppmr_phy_ctl_t [1:0]       phy_ctl,
  input  wire dppmr_sym_t [1:0]      line_rx,
  input  wire dppmr_sym_t [1:0]      mac_tx,
  output dppmr_sym_t [1:0]           line_tx,
  output dppmr_sym_t [1:0]           mac_rx
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DPPMR_BW-1:0]       bank;
    logic [1:0][15:0]          ctl;
    logic [1:0][15:0]          adv;
    logic [1:0][4:0]           partner;
    logic [1:0]                link;
    logic                      fef;
    logic [DPPMR_DW-1:0]       rdata;
    dppmr_phy_ctl_t [1:0]      pctl;
    dppmr_sym_t [1:0]          ltx;
    dppmr_sym_t [1:0]          mrx;
  } dppmr_state_t;

  dppmr_state_t st_r;
  dppmr_state_t st_nxt;

  // Bank decode, shared by the read and write paths
  function automatic logic [1:0] port_hit(input logic [DPPMR_BW-1:0] bank);
    port_hit = {bank == DPPMR_BANK_PORT2, bank == DPPMR_BANK_PORT1};
  endfunction

  function automatic logic [15:0] ability_word(input logic [4:0] abl);
    ability_word = ZERO16;
    ability_word[ABL_PAUSE]           = abl[4];
    ability_word[ABL_LOW+3:ABL_LOW]   = abl[3:0];
  endfunction

  logic [1:0] hit;
  logic       sel;
  logic       any_hit;

  always_comb begin
    hit     = port_hit(st_r.bank);
    sel     = hit[1];
    any_hit = |hit;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [15:0] rd_word;
    logic [1:0]  restart;
    logic        an_act;
    logic        lb;
    st_nxt  = st_r;
    rd_word = ZERO16;
    restart = 2'b00;
    an_act  = 1'b0;
    lb      = 1'b0;

    // Bank select sits outside the banked space so it stays reachable
    if (reg_wr && reg_addr == DPPMR_OFS_BANK) begin
      st_nxt.bank = reg_wdata[DPPMR_BW-1:0];
    end

    // One copy of every control bit; alias windows would share it
    if (reg_wr && any_hit && reg_addr == DPPMR_OFS_CTL) begin
      st_nxt.ctl[sel] = reg_wdata & CTL_WR_MASK;
      restart[sel]    = reg_wdata[CTL_AN_RESTART];
    end
    if (reg_wr && any_hit && reg_addr == DPPMR_OFS_ADV) begin
      st_nxt.adv[sel] = reg_wdata & ADV_WR_MASK;
    end

    // Status sampled every cycle
    st_nxt.fef = phy_sts[0].far_fault & ~st_r.ctl[0][CTL_FEF_OFF];
    for (int p = 0; p < 2; p++) begin
      st_nxt.link[p]    = phy_sts[p].link_up;
      st_nxt.partner[p] = phy_sts[p].partner;
    end

    // Read mux; data stands only in the cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == DPPMR_OFS_BANK) begin
        rd_word[DPPMR_BW-1:0] = st_r.bank;
      end else if (any_hit) begin
        unique case (reg_addr)
          DPPMR_OFS_CTL: rd_word = st_r.ctl[sel];
          DPPMR_OFS_STS: begin
            rd_word = STS_FIXED;
            rd_word[STS_LINK] = st_r.link[sel];
            rd_word[STS_FEF]  = ~sel & st_r.fef;
          end
          DPPMR_OFS_IDL: rd_word = ID_LOW;
          DPPMR_OFS_IDH: rd_word = ID_HIGH;
          DPPMR_OFS_ADV: rd_word = st_r.adv[sel] | ADV_SELECTOR;
          DPPMR_OFS_LPA: rd_word = ability_word(st_r.partner[sel]) | LPA_LOW_FIXED;
          default:       rd_word = ZERO16;
        endcase
      end
    end
    st_nxt.rdata = rd_word;

    // Transceiver controls; port 1 (index 0) has no negotiation engine
    for (int p = 0; p < 2; p++) begin
      an_act = (p == 1) && st_r.ctl[p][CTL_AN_EN];
      st_nxt.pctl[p].an_en        = an_act;
      st_nxt.pctl[p].an_restart   = restart[p] && (p == 1);
      st_nxt.pctl[p].speed_100    = an_act ? phy_sts[p].an_res_100
                                           : st_r.ctl[p][CTL_SPEED_100];
      st_nxt.pctl[p].full_duplex  = (!an_act || phy_sts[p].an_fail) ? st_r.ctl[p][CTL_FULL_DUPLEX]
                                                                    : phy_sts[p].an_res_full;
      st_nxt.pctl[p].power_down   = st_r.ctl[p][CTL_PWR_DOWN];
      st_nxt.pctl[p].xover_alg    = st_r.ctl[p][CTL_XOVER_ALG];
      st_nxt.pctl[p].auto_mdix_en = ~st_r.ctl[p][CTL_MDIX_OFF] & ~st_r.ctl[p][CTL_FORCE_MDIX];
      // Forcing crossed pairs wins over the disable bit
      st_nxt.pctl[p].mdix_sel     = st_r.ctl[p][CTL_FORCE_MDIX] |
                                    (~st_r.ctl[p][CTL_MDIX_OFF] & phy_sts[p].mdix_auto);
      st_nxt.pctl[p].fef_det_en   = (p == 0) && !st_r.ctl[p][CTL_FEF_OFF];
      st_nxt.pctl[p].tx_off       = st_r.ctl[p][CTL_TX_OFF];
      st_nxt.pctl[p].led_on       = phy_sts[p].link_up & ~st_r.ctl[p][CTL_LED_OFF];
      st_nxt.pctl[p].advertise    = {st_r.adv[p][ABL_PAUSE], st_r.adv[p][ABL_LOW+3:ABL_LOW]};

      // Far-end loop of this port's line is owned by the other port's bit
      lb = st_r.ctl[1-p][CTL_FAR_LB];
      st_nxt.ltx[p] = lb ? line_rx[p] : mac_tx[p];
      if (st_r.ctl[p][CTL_TX_OFF] || st_r.ctl[p][CTL_PWR_DOWN]) begin
        st_nxt.ltx[p] = '0;
      end
      st_nxt.mrx[p] = st_r.ctl[p][CTL_PWR_DOWN] ? '0 : line_rx[p];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r         <= '0;
      st_r.bank    <= DPPMR_BANK_RST;
      st_r.ctl     <= {CTL_RST, CTL_RST};
      st_r.adv     <= {ADV_RST, ADV_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    reg_rdata = st_r.rdata;
    phy_ctl   = st_r.pctl;
    line_tx   = st_r.ltx;
    mac_rx    = st_r.mrx;
  end

endmodule

//--- test/dppmr_regs_asserts.sv
// Port-level assertions for the transceiver register bank.
// Assumes a bind onto dppmr_regs from the bench top file.
`timescale 1ns/1ps
module dppmr_regs_asserts
  import dppmr_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic [DPPMR_AW-1:0]  reg_addr,
  input wire logic [DPPMR_DW-1:0]  reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [DPPMR_DW-1:0]  reg_rdata,
  input wire dppmr_phy_sts_t [1:0] phy_sts,
  input wire dppmr_phy_ctl_t [1:0] phy_ctl,
  input wire dppmr_sym_t [1:0]     line_rx,
  input wire dppmr_sym_t [1:0]     mac_tx,
  input wire dppmr_sym_t [1:0]     line_tx,
  input wire dppmr_sym_t [1:0]     mac_rx
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Checks
  // ****************************************
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == ZERO16) else $error("rdata leak");
  a_port1_no_neg: assert property (!phy_ctl[0].an_en && !phy_ctl[0].an_restart) else $error("p1 neg");
  a_tx_off_quiet: assert property (phy_ctl[0].tx_off |-> line_tx[0] == '0) else $error("tx on");
  // Guarded by past reset: the first symbol after release was launched in reset
  a_rx_path: assert property ($past(nrst) |-> mac_rx[1] == (phy_ctl[1].power_down ? '0 : $past(line_rx[1])))
    else $error("rx path");
  a_led_link: assert property (phy_ctl[1].led_on |-> $past(phy_sts[1].link_up)) else $error("led");
  a_speed_neg: assert property (phy_ctl[1].an_en |-> phy_ctl[1].speed_100 == $past(phy_sts[1].an_res_100))
    else $error("speed");
  a_duplex_neg: assert property (phy_ctl[1].an_en && !$past(phy_sts[1].an_fail)
    |-> phy_ctl[1].full_duplex == $past(phy_sts[1].an_res_full)) else $error("duplex");
  a_restart_src: assert property ($rose(phy_ctl[1].an_restart) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("restart");
  c_restart: cover property (phy_ctl[1].an_restart);
  c_read: cover property (reg_rd ##1 reg_rdata != ZERO16);
  c_fault: cover property (phy_ctl[0].fef_det_en && phy_sts[0].far_fault);
endmodule

//--- test/dppmr_link_partner.sv
// Remote link partner: status levels and receive symbols for both ports.
// Assumes the bench sets link, fault, send and ability as levels.
`timescale 1ns/1ps
module dppmr_link_partner
  import dppmr_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            link_on,
  input  wire logic            fault,
  input  wire logic            send,
  input  wire logic [4:0]      ability,
  output dppmr_phy_sts_t [1:0] sts,
  output dppmr_sym_t [1:0]     rx
);
  logic [3:0] cnt = 4'h0;
  initial rx = '0;
  // Data toggles even when idle so a stale symbol never passes for a match
  always @(posedge sys_clk) begin
    cnt <= cnt + 4'h5;
    rx  <= {send, ~cnt, send, cnt};
  end
  assign sts = {2{link_on, fault, ability == 5'h00, ability[3] | ability[2], ability[3] | ability[1], cnt[0], ability}};
endmodule

//--- test/tb.sv
// Self-checking bench for the transceiver register bank.
// Assumes the link partner model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb
  import dppmr_pkg::*;
;
  localparam logic [15:0] ID_L = 16'h3C3C;  // Arbitrary value
  localparam logic [15:0] ID_H = 16'hC3C3;  // Arbitrary value
  logic                 sys_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [DPPMR_AW-1:0]  reg_addr = '0;
  logic [DPPMR_DW-1:0]  reg_wdata = '0, reg_rdata;
  dppmr_phy_sts_t [1:0] phy_sts;
  dppmr_phy_ctl_t [1:0] phy_ctl;
  dppmr_sym_t [1:0]     line_rx, rx_q, tx_q, line_tx, mac_rx, mac_tx = '0;
  logic                 link_on = 1'h0, fault = 1'h0, send = 1'h0;
  logic [4:0]           ability = 5'h00;
  logic [3:0]           tcnt = 4'h0;
  int                   fail_count = 0, n_checks = 0, restarts = 0;

  dppmr_regs #(.ID_LOW(ID_L), .ID_HIGH(ID_H)) i_dppmr_regs (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .phy_sts, .phy_ctl, .line_rx, .mac_tx, .line_tx, .mac_rx);
  dppmr_link_partner i_dppmr_link_partner (.sys_clk, .link_on, .fault, .send, .ability, .sts(phy_sts), .rx(line_rx));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tcnt   <= tcnt + 4'h3;
    mac_tx <= {1'h0, ~tcnt, 1'h1, tcnt};
    rx_q   <= line_rx;
    tx_q   <= mac_tx;
    if (phy_ctl[1].an_restart === 1'h1) restarts <= restarts + 1;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  // Control outputs trail the write edge by one cycle
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic lbchk(input int p, input logic lp);
    repeat (4) begin
      @(negedge sys_clk);
      `CHK("line_tx", lp ? rx_q[p] : tx_q[p], line_tx[p])
      `CHK("mac_rx", rx_q[p], mac_rx[p])
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst    <= 1'h1;
    link_on <= 1'h1;
    send    <= 1'h1;
    rd(DPPMR_OFS_CTL, ZERO16);
    for (int p = 0; p < 2; p++) begin
      wr(DPPMR_OFS_BANK, {8'h00, p ? DPPMR_BANK_PORT2 : DPPMR_BANK_PORT1});
      rd(DPPMR_OFS_CTL, 16'h1020);
      rd(DPPMR_OFS_STS, 16'h780C);
      rd(DPPMR_OFS_IDL, ID_L);
      rd(DPPMR_OFS_IDH, ID_H);
      rd(DPPMR_OFS_ADV, 16'h05E1);
      rd(DPPMR_OFS_LPA, p ? 16'h04A1 : 16'h0001);
      ability <= 5'h15;
      wr(DPPMR_OFS_CTL, 16'hFFFF);
      rd(DPPMR_OFS_CTL, 16'h793F);
      settle();
      `CHK("an_en", 1'(p), phy_ctl[p].an_en)
      `CHK("pwr_dn", 1'h1, phy_ctl[p].power_down)
      `CHK("mdix", 2'h2, {phy_ctl[p].mdix_sel, phy_ctl[p].auto_mdix_en})
      `CHK("led", 1'h0, phy_ctl[p].led_on)
      `CHK("tx_off", 5'h00, line_tx[p])
      wr(DPPMR_OFS_CTL, 16'h0100);
      settle();
      `CHK("forced", 3'h1, {phy_ctl[p].speed_100, phy_ctl[p].xover_alg, phy_ctl[p].full_duplex})
      `CHK("fef_en", 1'(p == 0), phy_ctl[p].fef_det_en)
      lbchk(p, 1'h0);
      wr(DPPMR_OFS_ADV, 16'hFFFF);
      rd(DPPMR_OFS_ADV, 16'h07E1);
      `CHK("adv_out", 5'h1F, phy_ctl[p].advertise)
    end
    `CHK("restarts", 1, restarts)
    wr(DPPMR_OFS_BANK, {8'h00, DPPMR_BANK_PORT1});
    fault <= 1'h1;
    rd(DPPMR_OFS_STS, 16'h781C);
    wr(DPPMR_OFS_CTL, 16'h4004);
    rd(DPPMR_OFS_STS, 16'h780C);
    lbchk(1, 1'h1);
    wr(DPPMR_OFS_BANK, {8'h00, DPPMR_BANK_PORT2});
    rd(DPPMR_OFS_STS, 16'h780C);
    wr(DPPMR_OFS_CTL, 16'h4000);
    settle();
    lbchk(0, 1'h1);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule

bind dppmr_regs dppmr_regs_asserts i_dppmr_regs_asserts (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .phy_sts, .phy_ctl, .line_rx, .mac_tx, .line_tx, .mac_rx);
